// ===== common/eqcs_map.vh
// Contract
// RULE_01: enable high runs all channels normally; low puts them in standby.
// RULE_02: undriven enable reads high, so normal operation is the default.
// RULE_03: one enable acts on all data channels and the clock channel together.
// RULE_04: source select high takes boost level from the three boost pins.
// RULE_05: source select low takes boost level from the serial-bus register.
// RULE_06: undriven source select reads high, so pin boost is default.
// RULE_07: register access allowed only while chip select is high.
// RULE_08: undriven chip select reads low, so register access is off.
// RULE_09: serial clock is gated by chip select; edges ignored while low.
// RULE_10: data line is two-way, driven or released, idles high when undriven; the code never drives it, output enable is held low.
// RULE_11: host supplies the serial clock; device never drives it.
// RULE_12: three-bit code selects one of eight boost levels, pins or register.
// RULE_13: undriven boost pins read low, giving code zero under pin control.
// RULE_14: signal-detect output reports loss of signal on the clock channel.
// RULE_15: enable, source select and boost pins are synchronised before use.
`ifndef EQCS_MAP_VH
`define EQCS_MAP_VH
`define EQCS_BOOST_W      3
`define EQCS_CHAN_N       4
`define EQCS_BOOST_RST    3'h0
`define EQCS_SYNC_STAGES  2
`define EQCS_CHAN_RST     4'hF
`define EQCS_EN_RST       1'h1
`define EQCS_SRC_RST      1'h1
`define EQCS_CS_RST       1'h0
`endif

// ===== hdl/eqcs_ctrl.v
`timescale 1ns/100ps
`include "eqcs_map.vh"

module eqcs_ctrl
(
    input  wire                     i_clk,
    input  wire                     i_rst,
    input  wire                     i_ce,
    input  wire                     i_enable,
    input  wire                     i_enable_drv,
    input  wire                     i_boost_source_select,
    input  wire                     i_boost_source_select_drv,
    input  wire                     i_boost_level_bit0,
    input  wire                     i_boost_level_bit1,
    input  wire                     i_boost_level_bit2,
    input  wire [2:0]               i_boost_level_drv,
    input  wire                     i_chip_select,
    input  wire                     i_chip_select_drv,
    input  wire                     i_smbus_clock_pin,
    input  wire                     i_smbus_data_in,
    input  wire                     i_reg_wr,
    input  wire [2:0]               i_reg_boost,
    input  wire                     i_clk_chan_active,
    output reg                      o_smbus_data_out,
    output reg                      o_smbus_data_oe,
    output wire                     o_smbus_clk_gated,
    output reg                      o_reg_access_en,
    output reg  [3:0]               o_chan_enable,
    output reg                      o_standby,
    output reg  [2:0]               o_boost_level,
    output reg  [2:0]               o_reg_boost_q,
    output reg                      o_signal_detect_out
);

    // pull resolution of undriven pins
    wire       en_pin   = i_enable_drv ? i_enable : 1'b1;                 // RULE_02
    wire       src_pin  = i_boost_source_select_drv ? i_boost_source_select : 1'b1; // RULE_06
    wire [2:0] bst_raw  = {i_boost_level_bit2, i_boost_level_bit1, i_boost_level_bit0};
    wire [2:0] bst_pin  = bst_raw & i_boost_level_drv;                     // RULE_13
    wire       cs_pin   = i_chip_select_drv ? i_chip_select : 1'b0;       // RULE_08

    reg        en_meta_r;
    reg        en_sync_r;
    reg        src_meta_r;
    reg        src_sync_r;
    reg  [2:0] bst_meta_r;
    reg  [2:0] bst_sync_r;
    reg        cs_meta_r;
    reg        cs_sync_r;

    // two-stage synchroniser for enable
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            en_meta_r <= `EQCS_EN_RST;
            en_sync_r <= `EQCS_EN_RST;
        end
        else if (i_ce)
        begin
            en_meta_r <= en_pin;                                           // RULE_15
            en_sync_r <= en_meta_r;
        end
    end

    // two-stage synchroniser for source select
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            src_meta_r <= `EQCS_SRC_RST;
            src_sync_r <= `EQCS_SRC_RST;
        end
        else if (i_ce)
        begin
            src_meta_r <= src_pin;                                         // RULE_15
            src_sync_r <= src_meta_r;
        end
    end

    // two-stage synchroniser for boost pins
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            bst_meta_r <= `EQCS_BOOST_RST;
            bst_sync_r <= `EQCS_BOOST_RST;
        end
        else if (i_ce)
        begin
            bst_meta_r <= bst_pin;                                         // RULE_15
            bst_sync_r <= bst_meta_r;
        end
    end

    // two-stage synchroniser for chip select
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cs_meta_r <= `EQCS_CS_RST;
            cs_sync_r <= `EQCS_CS_RST;
        end
        else if (i_ce)
        begin
            cs_meta_r <= cs_pin;
            cs_sync_r <= cs_meta_r;
        end
    end

    wire en_s  = en_sync_r;
    wire src_s = src_sync_r;

    // serial clock only reaches the interface while selected
    assign o_smbus_clk_gated = i_smbus_clock_pin & cs_pin;                 // RULE_09 RULE_11

    reg [2:0] reg_boost_nxt;
    reg [2:0] boost_nxt;

    always @*
    begin
        reg_boost_nxt = o_reg_boost_q;
        if (i_reg_wr && cs_sync_r)
            reg_boost_nxt = i_reg_boost;                                   // RULE_07 RULE_12
        boost_nxt = src_s ? bst_sync_r : o_reg_boost_q;                    // RULE_04 RULE_05
    end

    // boost register, written only while selected
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_reg_boost_q <= `EQCS_BOOST_RST;
        end
        else if (i_ce)
        begin
            o_reg_boost_q <= reg_boost_nxt;                                // RULE_07
        end
    end

    // applied boost level
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_boost_level <= `EQCS_BOOST_RST;
        end
        else if (i_ce)
        begin
            o_boost_level <= boost_nxt;                                    // RULE_12
        end
    end

    // one enable for all channels
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_chan_enable <= `EQCS_CHAN_RST;
        end
        else if (i_ce)
        begin
            o_chan_enable <= {`EQCS_CHAN_N{en_s}};                         // RULE_01 RULE_03
        end
    end

    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_standby <= 1'h0;
        end
        else if (i_ce)
        begin
            o_standby <= ~en_s;                                            // RULE_01
        end
    end

    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_reg_access_en <= 1'h0;
        end
        else if (i_ce)
        begin
            o_reg_access_en <= cs_sync_r;                                  // RULE_07
        end
    end

    // detect held low in standby
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_signal_detect_out <= 1'h0;
        end
        else if (i_ce)
        begin
            o_signal_detect_out <= en_s & i_clk_chan_active;               // RULE_14
        end
    end

    // data line released (pulled high); no read engine drives it
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_smbus_data_out <= 1'h0;
            o_smbus_data_oe  <= 1'h0;
        end
        else if (i_ce)
        begin
            o_smbus_data_out <= 1'h0;
            o_smbus_data_oe  <= cs_sync_r & ~i_smbus_data_in & 1'h0;       // RULE_10
        end
    end

endmodule // eqcs_ctrl

// ===== verif/eqcs_host.sv
`timescale 1ns/100ps
module eqcs_host(
    input  wire i_clk, i_run, i_oe, i_out,
    output reg  o_scl = 1'h1,
    output wire o_sda);
    always @(posedge i_clk) o_scl <= i_run ? !o_scl : 1'h1;
    assign o_sda = i_oe ? i_out : 1'h1;
endmodule // eqcs_host

// ===== verif/eqcs_ctrl_assertions.sv
`timescale 1ns/100ps
module eqcs_chk(
    input wire i_clk, i_rst, i_enable, i_enable_drv, i_chip_select, i_chip_select_drv,
    input wire i_boost_source_select, i_boost_source_select_drv, i_smbus_clock_pin,
    input wire o_smbus_data_oe, o_smbus_clk_gated, o_reg_access_en, o_standby, o_signal_detect_out,
    input wire [2:0] o_boost_level, o_reg_boost_q,
    input wire [3:0] o_chan_enable);
    reg  [1:0] n_r = 2'h0;
    wire e = !i_enable_drv | i_enable, c = i_chip_select_drv & i_chip_select, ok = n_r == 2'h3;
    wire f = !i_boost_source_select_drv | i_boost_source_select;
    // settle count so that three-deep history is from after reset
    always @(posedge i_clk) n_r <= i_rst ? 2'h0 : n_r + {1'h0, !ok};
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_STBY: assert property (ok |-> o_standby != $past(e,3)) else $error("standby");
    AST_CHAN: assert property (ok |-> o_chan_enable == {4{$past(e,3)}}) else $error("chan");
    AST_REGB: assert property (ok && !$past(f,3) |-> o_boost_level == $past(o_reg_boost_q))
        else $error("boost");
    AST_ACCH: assert property (c [*4] |=> o_reg_access_en) else $error("access");
    AST_ACCL: assert property (!c [*4] |=> !o_reg_access_en && $stable(o_reg_boost_q))
        else $error("access");
    AST_GATE: assert property (o_smbus_clk_gated == (i_smbus_clock_pin & c))
        else $error("gate");
    AST_OE: assert property (!o_smbus_data_oe) else $error("data driven");
    AST_DET: assert property (o_standby |-> !o_signal_detect_out) else $error("detect");
    cover property (o_standby);
    cover property (c && o_reg_access_en);
    cover property (o_smbus_clk_gated);
endmodule // eqcs_chk
bind eqcs_ctrl eqcs_chk chk(.*);

// ===== verif/equalizer_control_select_test.sv
`timescale 1ns/100ps
module equalizer_control_select_test;
    reg i_clk = 0, i_rst = 1, i_enable = 0, i_enable_drv = 0, i_reg_wr = 0, run = 0, i_chip_select = 1;
    reg i_boost_source_select = 0, i_boost_source_select_drv = 0, i_clk_chan_active = 0;
    reg i_chip_select_drv = 0, i_boost_level_bit0 = 0, i_boost_level_bit1 = 0, i_boost_level_bit2 = 0;
    reg  [2:0] i_boost_level_drv = 0, i_reg_boost = 0;
    wire i_smbus_clock_pin, i_smbus_data_in, o_smbus_data_out, o_smbus_data_oe, o_smbus_clk_gated;
    wire o_reg_access_en, o_standby, o_signal_detect_out;
    wire [2:0] o_boost_level, o_reg_boost_q;
    wire [3:0] o_chan_enable;
    integer num_errors = 0, compares = 0, i;
    always #5 i_clk = ~i_clk;
    eqcs_host host(.i_clk, .i_run(run), .i_oe(o_smbus_data_oe), .i_out(o_smbus_data_out),
        .o_scl(i_smbus_clock_pin), .o_sda(i_smbus_data_in));
    eqcs_ctrl dut(.*, .i_ce(1'h1));
    task cyc(input integer k); repeat (k) @(posedge i_clk); endtask
    task chk(input string n, input [3:0] s, e);
        compares++; num_errors += s !== e;
        if (s !== e) $display("MISMATCH %0s expected %h seen %h", n, e, s);
    endtask
    task conclude;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task t_enable(input integer k);
        i_enable <= k == 0; i_enable_drv <= k < 2; i_clk_chan_active <= k != 2; cyc(5);
        chk("standby", o_standby, k == 1);
        chk("chan", o_chan_enable, {4{k != 1}});
        chk("detect", o_signal_detect_out, k == 0 || k == 3);
    endtask
    task t_boost(input integer k);
        {i_boost_level_bit2, i_boost_level_bit1, i_boost_level_bit0} <= k | k / 8 * 7;
        i_boost_level_drv <= k < 8 ? 7 : 0; cyc(5);
        chk("pin boost", o_boost_level, k % 8);
    endtask
    task t_reg;
        i_reg_boost <= 5; i_reg_wr <= 1; cyc(1); i_reg_wr <= 0; cyc(2);
        chk("refused", o_reg_boost_q, 0);
        chk("access off", o_reg_access_en, 0);
        chk("gate off", o_smbus_clk_gated, 0);
        i_chip_select_drv <= 1; i_boost_source_select_drv <= 1; cyc(4);
        chk("access on", o_reg_access_en, 1);
        chk("gate on", o_smbus_clk_gated, i_smbus_clock_pin);
        chk("released", o_smbus_data_oe, 0);
        chk("line idle", i_smbus_data_in, 1);
        i_reg_wr <= 1; i_reg_boost <= 3; cyc(1); i_reg_boost <= 6; cyc(1); i_reg_wr <= 0; cyc(3);
        chk("reg", o_reg_boost_q, 6);
        chk("reg boost", o_boost_level, 6);
    endtask
    initial
    begin
        cyc(16); i_rst <= 0; run <= 1;
        for (i = 0; i < 4; i++) t_enable(i);
        for (i = 0; i < 9; i++) t_boost(i);
        t_reg; conclude;
    end
endmodule // equalizer_control_select_test
